// >>> logic/mnsx_exec.sv
/*
  Execution of store, multiply, negate, idle, pop and push opcodes with
  their shared file operand addressing, on four quarter-cycle phases.
  Assumes the instruction word, program counter and addressing context
  are synchronous to clk; word and counter held during the first phase
  of a cycle, addressing context from the second to the fourth.
*/
`timescale 1ns/1ps
`include "mnsx_cfg.svh"

// Notes on behaviour
// - store copies the accumulator to the file byte, flags untouched
// - literal multiply takes accumulator times immediate, accumulator kept
// - both multiplies write the 16-bit product, high byte high register
// - file multiply takes accumulator times file byte, both kept
// - multiplies change no flag, no carry, overflow or zero mark
// - negate writes inverse plus one back to the same file byte
// - negate sets negative, wrap, carry, half carry and zero flags
// - bank bit clear picks the access bank, set picks the bank pointer
// - extended set, bank bit clear, operand up to 5f: indexed offset
// - pop discards the stack head in one single-word instruction
// - after a pop the head is the entry pushed just before
// - push places program counter plus two on the stack head
// - on a push the old head moves one level deeper
module mnsx_exec
  import mnsx_pkg::*;
#(
  parameter int STACK_DEPTH = `MNSX_STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [`MNSX_PC_W-1:0] prog_counter,
  // addressing context
  input wire logic ext_set_en,
  input wire logic [`MNSX_ADDR_W-1:0] index_base,
  // loads from the rest of the core
  input wire logic acc_load,
  input wire logic [7:0] acc_load_data,
  input wire logic bank_load,
  input wire logic [3:0] bank_load_data,
  // phase and completion
  output logic [3:0] phase,
  output logic instr_done_r,
  // core registers
  output logic [7:0] acc_r,
  output logic [3:0] bank_pointer_r,
  output logic [7:0] product_high_r,
  output logic [7:0] product_low_r,
  // status flags
  output logic neg_flag_r,
  output logic sign_wrap_flag_r,
  output logic carry_flag_r,
  output logic half_carry_flag_r,
  output logic zero_flag_r,
  // return stack
  output logic [`MNSX_PC_W-1:0] stack_head,
  output logic stack_empty,
  // file write observation
  output logic file_wr_en_r,
  output logic [`MNSX_ADDR_W-1:0] file_wr_addr_r,
  output logic [7:0] file_wr_data_r
);
  mnsx_phase_t phase_r;
  mnsx_phase_t phase_nxt;
  mnsx_op_t op_r;
  mnsx_op_t op_dec;
  mnsx_flags_t nflags_r;
  mnsx_flags_t nflags_nxt;
  logic valid_r;
  logic [15:0] ir_r;
  logic [`MNSX_PC_W-1:0] pc_r;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic [15:0] mult_r;
  logic [15:0] mult_nxt;

  mnsx_core_if #(.AW(`MNSX_ADDR_W), .PW(`MNSX_PC_W)) bus ();

  mnsx_ram #(.AW(`MNSX_ADDR_W)) u_ram (
    .clk(clk),
    .arst_n(arst_n),
    .bus(bus)
  );

  mnsx_stack #(.DEPTH(STACK_DEPTH), .PW(`MNSX_PC_W)) u_stack (
    .clk(clk),
    .arst_n(arst_n),
    .bus(bus)
  );

  // phase sequencer
  assign phase_nxt = (phase_r == PH_Q1) ? PH_Q2 :
                     (phase_r == PH_Q2) ? PH_Q3 :
                     (phase_r == PH_Q3) ? PH_Q4 : PH_Q1;
  wire in_q1 = (phase_r == PH_Q1);
  wire in_q2 = (phase_r == PH_Q2);
  wire in_q3 = (phase_r == PH_Q3);
  wire in_q4 = (phase_r == PH_Q4);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;

  // decode; unknown words fall to idle as this block has no other work
  wire hit_store = (instr_word[15:9] == `MNSX_OPC_STORE);
  wire hit_mulf = (instr_word[15:9] == `MNSX_OPC_MULF);
  wire hit_neg = (instr_word[15:9] == `MNSX_OPC_NEG);
  wire hit_muli = (instr_word[15:8] == `MNSX_OPC_MULI);
  wire hit_pop = (instr_word == `MNSX_OPC_POP);
  wire hit_push = (instr_word == `MNSX_OPC_PUSH);
  assign op_dec = hit_store ? OP_STORE :
                  hit_mulf ? OP_MULF :
                  hit_neg ? OP_NEG :
                  hit_muli ? OP_MULI :
                  hit_pop ? OP_POP :
                  hit_push ? OP_PUSH : OP_IDLE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_r <= OP_IDLE;
      valid_r <= 1'b0;
      ir_r <= `MNSX_IR_RST;
      pc_r <= `MNSX_PC_RST;
    end else if (in_q1) begin
      op_r <= instr_valid ? op_dec : OP_IDLE;
      valid_r <= instr_valid;
      ir_r <= instr_word;
      pc_r <= prog_counter;
    end
  end

  // operand address
  wire [7:0] fsel = ir_r[7:0];
  wire bank_bit = ir_r[8];
  wire use_index = ext_set_en && !bank_bit && (fsel <= `MNSX_INDEX_LIMIT);
  wire [`MNSX_ADDR_W-1:0] addr_access = {{4{fsel[7]}}, fsel};
  wire [`MNSX_ADDR_W-1:0] addr_bank = {bank_pointer_r, fsel};
  wire [`MNSX_ADDR_W-1:0] addr_index = index_base + {4'h0, fsel};
  wire [`MNSX_ADDR_W-1:0] file_addr =
    use_index ? addr_index :
    bank_bit ? addr_bank : addr_access;
  wire writes_file = (op_r == OP_STORE) || (op_r == OP_NEG);

  assign bus.ram_addr = file_addr;
  assign bus.ram_we = in_q4 && writes_file;
  assign bus.ram_wdata = result_r;

  // stack requests; push in q2, pop in q3
  assign bus.stk_push = in_q2 && (op_r == OP_PUSH);
  assign bus.stk_pop = in_q3 && (op_r == OP_POP);
  assign bus.stk_wdata = pc_r + `MNSX_PUSH_STEP;
  assign stack_head = bus.stk_head;
  assign stack_empty = bus.stk_empty;

  // processing in q3
  wire [7:0] inv = ~bus.ram_rdata;
  wire [8:0] neg_sum = {1'b0, inv} + 9'h001;
  wire [4:0] neg_half = {1'b0, inv[3:0]} + 5'h01;
  wire [7:0] mul_opnd = (op_r == OP_MULI) ? fsel : bus.ram_rdata;
  assign result_nxt = (op_r == OP_NEG) ? neg_sum[7:0] : acc_r;
  assign mult_nxt = {8'h00, acc_r} * {8'h00, mul_opnd};
  assign nflags_nxt = '{
    neg: neg_sum[7],
    wrap: !inv[7] && neg_sum[7],
    carry: neg_sum[8],
    half: neg_half[4],
    zero: (neg_sum[7:0] == 8'h00)
  };

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= 8'h00;
      mult_r <= 16'h0000;
      nflags_r <= '0;
    end else if (in_q3) begin
      result_r <= result_nxt;
      mult_r <= mult_nxt;
      nflags_r <= nflags_nxt;
    end
  end

  // write back in q4; the accumulator only loads from outside
  wire do_mul = in_q4 && ((op_r == OP_MULI) || (op_r == OP_MULF));
  wire do_neg = in_q4 && (op_r == OP_NEG);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      product_high_r <= `MNSX_PROD_RST;
      product_low_r <= `MNSX_PROD_RST;
    end else if (do_mul) begin
      product_high_r <= mult_r[15:8];
      product_low_r <= mult_r[7:0];
    end
  end

  // multiplies never reach the flag registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {neg_flag_r, sign_wrap_flag_r, carry_flag_r} <= 3'h0;
      {half_carry_flag_r, zero_flag_r} <= 2'h0;
    end else if (do_neg) begin
      neg_flag_r <= nflags_r.neg;
      sign_wrap_flag_r <= nflags_r.wrap;
      carry_flag_r <= nflags_r.carry;
      half_carry_flag_r <= nflags_r.half;
      zero_flag_r <= nflags_r.zero;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= `MNSX_ACC_RST;
      bank_pointer_r <= `MNSX_BANK_RST;
    end else begin
      if (acc_load) begin
        acc_r <= acc_load_data;
      end
      if (bank_load) begin
        bank_pointer_r <= bank_load_data;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      file_wr_en_r <= 1'b0;
      file_wr_addr_r <= '0;
      file_wr_data_r <= 8'h00;
      instr_done_r <= 1'b0;
    end else begin
      file_wr_en_r <= bus.ram_we;
      file_wr_addr_r <= bus.ram_addr;
      file_wr_data_r <= bus.ram_wdata;
      instr_done_r <= in_q4 && valid_r;
    end
  end

  // checks
  property p_phase_cycle;
    @(posedge clk) disable iff (!arst_n)
      in_q1 |=> in_q2 ##1 in_q3 ##1 in_q4 ##1 in_q1;
  endproperty
  a_phase_cycle: assert property (p_phase_cycle)
    else $error("phase did not rotate through four quarters");

  property p_store_acc;
    @(posedge clk) disable iff (!arst_n)
      in_q3 && op_r == OP_STORE && !acc_load |-> ##1
        (bus.ram_we && bus.ram_wdata == $past(acc_r)) ##1
        (file_wr_en_r && $stable(acc_r) && $stable(zero_flag_r));
  endproperty
  a_store_acc: assert property (p_store_acc)
    else $error("store did not write the accumulator");

  property p_mul_imm;
    @(posedge clk) disable iff (!arst_n)
      in_q3 && op_r == OP_MULI |-> ##2
        {product_high_r, product_low_r} ==
        {8'h00, $past(acc_r, 2)} * {8'h00, $past(ir_r[7:0], 2)};
  endproperty
  a_mul_imm: assert property (p_mul_imm)
    else $error("literal product wrong");

  property p_mul_file;
    @(posedge clk) disable iff (!arst_n)
      in_q3 && op_r == OP_MULF |-> ##2
        product_high_r == 8'(({8'h00, $past(acc_r, 2)} *
        {8'h00, $past(bus.ram_rdata, 2)}) >> 8) && !file_wr_en_r;
  endproperty
  a_mul_file: assert property (p_mul_file)
    else $error("file product high byte wrong or file written");

  property p_mul_flags;
    @(posedge clk) disable iff (!arst_n)
      do_mul |=> $stable({neg_flag_r, sign_wrap_flag_r, carry_flag_r,
        half_carry_flag_r, zero_flag_r});
  endproperty
  a_mul_flags: assert property (p_mul_flags)
    else $error("multiply changed a flag");

  property p_neg_write;
    @(posedge clk) disable iff (!arst_n)
      in_q3 && op_r == OP_NEG |-> ##1 bus.ram_we &&
        bus.ram_wdata == 8'(~$past(bus.ram_rdata) + 8'h01) &&
        bus.ram_addr == $past(bus.ram_addr);
  endproperty
  a_neg_write: assert property (p_neg_write)
    else $error("negate wrote a wrong value or location");

  property p_neg_flags;
    @(posedge clk) disable iff (!arst_n)
      in_q3 && op_r == OP_NEG && bus.ram_rdata == 8'h80 |-> ##2
        sign_wrap_flag_r && neg_flag_r && !zero_flag_r && !carry_flag_r;
  endproperty
  a_neg_flags: assert property (p_neg_flags)
    else $error("negate of 80 flags wrong");

  property p_bank_addr;
    @(posedge clk) disable iff (!arst_n)
      in_q2 && writes_file && bank_bit |->
        bus.ram_addr == {bank_pointer_r, ir_r[7:0]};
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("banked operand address wrong");

  property p_index_addr;
    @(posedge clk) disable iff (!arst_n)
      in_q2 && ext_set_en && !ir_r[8] && ir_r[7:0] < 8'h60 |->
        bus.ram_addr == 12'(index_base + ir_r[7:0]);
  endproperty
  a_index_addr: assert property (p_index_addr)
    else $error("indexed operand address wrong");

  property p_push_pc;
    @(posedge clk) disable iff (!arst_n)
      in_q1 && instr_valid && instr_word == `MNSX_OPC_PUSH |-> ##2
        stack_head == $past(prog_counter, 2) + `MNSX_PUSH_STEP;
  endproperty
  a_push_pc: assert property (p_push_pc)
    else $error("push did not place pc plus two");

  property p_idle_quiet;
    @(posedge clk) disable iff (!arst_n)
      in_q2 && op_r == OP_IDLE |-> ##1 !bus.stk_pop ##1 !bus.ram_we
        ##1 $stable({product_high_r, product_low_r, zero_flag_r,
        stack_head});
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("idle changed state");
endmodule

// >>> common/mnsx_cfg.svh
/*
  Constants of the multiply, negate and stack execution block: widths,
  opcode patterns, reset values and the operand offset limit.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef MNSX_CFG_SVH
`define MNSX_CFG_SVH

// widths and sizes
`define MNSX_ADDR_W 12
`define MNSX_PC_W 21
`define MNSX_STACK_DEPTH 31

// opcode patterns, upper bits of the instruction word; pop and push match the whole word
`define MNSX_OPC_STORE 7'h37
`define MNSX_OPC_MULF 7'h01
`define MNSX_OPC_NEG 7'h36
`define MNSX_OPC_MULI 8'h0d
`define MNSX_OPC_POP 16'h0006
`define MNSX_OPC_PUSH 16'h0005

// addressing
`define MNSX_INDEX_LIMIT 8'h5f
`define MNSX_PUSH_STEP 21'h000002

// reset values
`define MNSX_ACC_RST 8'h00
`define MNSX_BANK_RST 4'h0
`define MNSX_PROD_RST 8'h00
`define MNSX_PC_RST 21'h000000
`define MNSX_IR_RST 16'h0000
`define MNSX_STK_RST 21'h000000

`endif

// >>> common/mnsx_pkg.sv
/*
  Types of the multiply, negate and stack execution block: quarter-cycle
  phases, decoded operations and the arithmetic flag set.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mnsx_pkg;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } mnsx_phase_t;

  typedef enum logic [6:0] {
    OP_IDLE = 7'h01,
    OP_STORE = 7'h02,
    OP_MULI = 7'h04,
    OP_MULF = 7'h08,
    OP_NEG = 7'h10,
    OP_POP = 7'h20,
    OP_PUSH = 7'h40
  } mnsx_op_t;

  typedef struct packed {
    logic neg;
    logic wrap;
    logic carry;
    logic half;
    logic zero;
  } mnsx_flags_t;

endpackage

// >>> common/mnsx_if.sv
/*
  Interface between the execution control and its file memory and
  return stack.  Assumes one clock; the control drives all requests.
*/
`timescale 1ns/1ps

interface mnsx_core_if #(
  parameter int AW = 12,
  parameter int PW = 21
);
  logic [AW-1:0] ram_addr;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic stk_push;
  logic stk_pop;
  logic [PW-1:0] stk_wdata;
  logic [PW-1:0] stk_head;
  logic stk_empty;

  modport ctrl (
    output ram_addr, ram_we, ram_wdata, stk_push, stk_pop, stk_wdata,
    input ram_rdata, stk_head, stk_empty
  );
  modport ram (
    input ram_addr, ram_we, ram_wdata,
    output ram_rdata
  );
  modport stk (
    input stk_push, stk_pop, stk_wdata,
    output stk_head, stk_empty
  );
endinterface

// >>> logic/mnsx_ram.sv
/*
  File register memory, one byte per address, registered read.
  Assumes a single clock; a write and a read of one address in one
  cycle return the old byte.
*/
`timescale 1ns/1ps

module mnsx_ram #(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // memory port
  mnsx_core_if.ram bus
);
  logic [7:0] mem [2**AW];
  logic [7:0] rdata_r;

  // array kept out of reset so it maps onto plain ram cells
  always_ff @(posedge clk) begin
    if (bus.ram_we) begin
      mem[bus.ram_addr] <= bus.ram_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= mem[bus.ram_addr];
    end
  end

  assign bus.ram_rdata = rdata_r;
endmodule

// >>> logic/mnsx_stack.sv
/*
  Hardware return stack as a shift register; entry 0 is the head.
  Assumes push and pop never come in the same cycle.
*/
`timescale 1ns/1ps
`include "mnsx_cfg.svh"

module mnsx_stack #(
  parameter int DEPTH = `MNSX_STACK_DEPTH,
  parameter int PW = `MNSX_PC_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // stack port
  mnsx_core_if.stk bus
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [PW-1:0] ent_r [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic empty_r;
  wire full = (cnt_r == CW'(DEPTH));
  wire empty = (cnt_r == '0);

  // a push when full drops the deepest entry
  genvar i;
  for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
    // index kept in range on the end entries, the select picks the constant or the pushed word
    wire [PW-1:0] below = (i == DEPTH - 1) ? PW'(`MNSX_STK_RST) :
      ent_r[(i == DEPTH - 1) ? i : i + 1];
    wire [PW-1:0] above = (i == 0) ? bus.stk_wdata :
      ent_r[(i == 0) ? 0 : i - 1];
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ent_r[i] <= `MNSX_STK_RST;
      end else if (bus.stk_push) begin
        ent_r[i] <= above;
      end else if (bus.stk_pop) begin
        ent_r[i] <= below;
      end
    end
  end

  assign cnt_nxt = (bus.stk_push && !full) ? cnt_r + CW'(1) :
                   (bus.stk_pop && !empty) ? cnt_r - CW'(1) : cnt_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      empty_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      empty_r <= (cnt_nxt == '0);
    end
  end

  assign bus.stk_head = ent_r[0];
  assign bus.stk_empty = empty_r;

  property p_push_sinks;
    @(posedge clk) disable iff (!arst_n)
      bus.stk_push |=> ent_r[1] == $past(ent_r[0]) &&
        ent_r[0] == $past(bus.stk_wdata);
  endproperty
  a_push_sinks: assert property (p_push_sinks)
    else $error("push did not move head one level down");

  property p_pop_rises;
    @(posedge clk) disable iff (!arst_n)
      bus.stk_pop && !bus.stk_push |=> ent_r[0] == $past(ent_r[1]);
  endproperty
  a_pop_rises: assert property (p_pop_rises)
    else $error("pop did not expose the entry beneath");
endmodule

// >>> testbench/tb_top.sv
/*
  Self-checking bench of the execution block: a table of store, multiply,
  negate and idle cases, then stack, phase, load and reset tests.
  Assumes the block's hand-over timing; inputs move on falling edges.
*/
`timescale 1ns/1ps
`include "mnsx_cfg.svh"

module tb_top
  import mnsx_pkg::*;
;
  localparam int DEPTH = 4;
  localparam int LIMIT = 2000;

  typedef struct packed {
    logic [15:0] w;
    logic [7:0] acc;
    logic [3:0] bank;
    logic ext;
    logic [11:0] base;
    logic wr;
    logic [11:0] addr;
    logic [7:0] data;
    logic [15:0] prod;
    logic [4:0] flg;
  } mnsx_row_t;

  logic clk, arst_n, instr_valid, ext_set_en, acc_load, bank_load;
  logic [15:0] instr_word;
  logic [`MNSX_PC_W-1:0] prog_counter, stack_head;
  logic [`MNSX_ADDR_W-1:0] index_base, file_wr_addr_r;
  logic [7:0] acc_load_data, acc_r, product_high_r, product_low_r;
  logic [7:0] file_wr_data_r;
  logic [3:0] bank_load_data, phase, bank_pointer_r;
  logic instr_done_r, stack_empty, file_wr_en_r;
  logic neg_flag_r, sign_wrap_flag_r, carry_flag_r;
  logic half_carry_flag_r, zero_flag_r;
  logic [4:0] flags_seen;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  mnsx_row_t rows [22];

  assign flags_seen = {neg_flag_r, sign_wrap_flag_r, carry_flag_r,
                       half_carry_flag_r, zero_flag_r};

  // small stack so that overflow is reached in a few pushes
  mnsx_exec #(.STACK_DEPTH(DEPTH)) i_mnsx_exec (
    .clk, .arst_n, .instr_valid, .instr_word, .prog_counter, .ext_set_en,
    .index_base, .acc_load, .acc_load_data, .bank_load, .bank_load_data,
    .phase, .instr_done_r, .acc_r, .bank_pointer_r, .product_high_r,
    .product_low_r, .neg_flag_r, .sign_wrap_flag_r, .carry_flag_r,
    .half_carry_flag_r, .zero_flag_r, .stack_head, .stack_empty,
    .file_wr_en_r, .file_wr_addr_r, .file_wr_data_r
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  // waits for a Q1 cycle, presents the word, returns in the Q2 cycle
  task automatic issue(input logic [15:0] w, input logic [20:0] pc);
    int n;
    n = 0;
    while (phase !== PH_Q1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    instr_valid = 1'b1;
    instr_word = w;
    prog_counter = pc;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask

  task automatic run_row(input mnsx_row_t r);
    acc_load = 1'b1;
    acc_load_data = r.acc;
    bank_load = 1'b1;
    bank_load_data = r.bank;
    ext_set_en = r.ext;
    index_base = r.base;
    issue(r.w, 21'h000124);
    acc_load = 1'b0;
    bank_load = 1'b0;
    repeat (3) @(negedge clk);
    check(instr_done_r, 1'b1, "done pulse");
    check(file_wr_en_r, r.wr, "file write");
    if (r.wr) begin
      check(file_wr_addr_r, r.addr, "write address");
      check(file_wr_data_r, r.data, "write data");
    end
    check({product_high_r, product_low_r}, r.prod, "product");
    check(flags_seen, r.flg, "flags");
    check(acc_r, r.acc, "accumulator kept");
    check(stack_head, 21'h0, "stack untouched");
  endtask

  task automatic check_reset();
    check(phase, PH_Q1, "reset phase");
    check({product_high_r, product_low_r}, 16'h0, "reset product");
    check(flags_seen, 5'h00, "reset flags");
    check({stack_empty, stack_head}, 22'h200000, "reset stack");
    check({instr_done_r, file_wr_en_r}, 2'h0, "reset pulses");
    check({acc_r, bank_pointer_r}, 12'h000, "reset registers");
  endtask

  initial begin
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    prog_counter = 21'h0;
    ext_set_en = 1'b0;
    index_base = 12'h000;
    acc_load = 1'b0;
    acc_load_data = 8'h00;
    bank_load = 1'b0;
    bank_load_data = 4'h0;
    rows = '{
    '{16'h6f23,8'h4f,4'h2,1'b0,12'h000,1'b1,12'h223,8'h4f,16'h0000,5'h00},
    '{16'h6e10,8'h3a,4'h2,1'b0,12'h000,1'b1,12'h010,8'h3a,16'h0000,5'h00},
    '{16'h6e90,8'hc4,4'h2,1'b0,12'h000,1'b1,12'hf90,8'hc4,16'h0000,5'h00},
    '{16'h6e20,8'hb5,4'h2,1'b1,12'h100,1'b1,12'h120,8'hb5,16'h0000,5'h00},
    '{16'h6e60,8'h11,4'h2,1'b1,12'h100,1'b1,12'h060,8'h11,16'h0000,5'h00},
    '{16'h6e5f,8'h22,4'h2,1'b1,12'hfff,1'b1,12'h05e,8'h22,16'h0000,5'h00},
    '{16'h6f40,8'h80,4'h3,1'b0,12'h000,1'b1,12'h340,8'h80,16'h0000,5'h00},
    '{16'h6f41,8'h00,4'h3,1'b0,12'h000,1'b1,12'h341,8'h00,16'h0000,5'h00},
    '{16'h0dc4,8'he2,4'h3,1'b0,12'h000,1'b0,12'h000,8'h00,16'had08,5'h00},
    '{16'h0290,8'hb5,4'h3,1'b0,12'h000,1'b0,12'h000,8'h00,16'h8a94,5'h00},
    '{16'h0323,8'hff,4'h2,1'b0,12'h000,1'b0,12'h000,8'h00,16'h4eb1,5'h00},
    '{16'h0220,8'h02,4'h2,1'b1,12'h100,1'b0,12'h000,8'h00,16'h016a,5'h00},
    '{16'h0d00,8'h55,4'h2,1'b0,12'h000,1'b0,12'h000,8'h00,16'h0000,5'h00},
    '{16'h6c10,8'h00,4'h2,1'b0,12'h000,1'b1,12'h010,8'hc6,16'h0000,5'h10},
    '{16'h6d40,8'h00,4'h3,1'b0,12'h000,1'b1,12'h340,8'h80,16'h0000,5'h1a},
    '{16'h6d41,8'h00,4'h3,1'b0,12'h000,1'b1,12'h341,8'h00,16'h0000,5'h07},
    '{16'h0340,8'h02,4'h3,1'b0,12'h000,1'b0,12'h000,8'h00,16'h0100,5'h07},
    '{16'h6c5f,8'h00,4'h2,1'b1,12'hfff,1'b1,12'h05e,8'hde,16'h0100,5'h10},
    '{16'h0000,8'h00,4'h2,1'b0,12'h000,1'b0,12'h000,8'h00,16'h0100,5'h10},
    '{16'hf123,8'h00,4'h2,1'b0,12'h000,1'b0,12'h000,8'h00,16'h0100,5'h10},
    '{16'h0001,8'h00,4'h2,1'b0,12'h000,1'b0,12'h000,8'h00,16'h0100,5'h10},
    '{16'h0d02,8'h80,4'h0,1'b0,12'h000,1'b0,12'h000,8'h00,16'h0100,5'h00}};
    repeat (4) @(negedge clk);
    check_reset();
    arst_n = 1'b1;
    for (int i = 0; i < 21; i++) begin
      run_row(rows[i]);
    end
    // one push more than the stack holds: the oldest entry is lost
    for (int i = 0; i < DEPTH + 1; i++) begin
      issue(`MNSX_OPC_PUSH, {5'(i), 16'h0124});
      check(stack_head, i == 0 ? 21'h0 : {5'(i - 1), 16'h0126},
            "head before q2");
      @(negedge clk);
      check(stack_head, {5'(i), 16'h0126}, "pushed head");
      repeat (2) @(negedge clk);
    end
    for (int i = DEPTH - 1; i >= 0; i--) begin
      issue(`MNSX_OPC_POP, 21'h0);
      @(negedge clk);
      check(stack_head, {5'(i + 1), 16'h0126}, "head before q3");
      @(negedge clk);
      check(stack_head, i == 0 ? 21'h0 : {5'(i), 16'h0126},
            "popped head");
      @(negedge clk);
    end
    check(stack_empty, 1'b1, "deepest entry dropped");
    // a word offered outside q1 must be ignored
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word = 16'h6f23;
    repeat (3) @(negedge clk);
    instr_valid = 1'b0;
    repeat (5) begin
      @(negedge clk);
      check({instr_done_r, file_wr_en_r}, 2'h0, "late word");
    end
    // accumulator reloaded in q2 is the value that gets stored
    acc_load = 1'b1;
    acc_load_data = 8'h11;
    bank_load = 1'b1;
    bank_load_data = 4'h5;
    ext_set_en = 1'b0;
    issue(16'h6f50, 21'h0);
    acc_load_data = 8'h99;
    @(negedge clk);
    acc_load = 1'b0;
    bank_load = 1'b0;
    repeat (2) @(negedge clk);
    check(file_wr_data_r, 8'h99, "operand from q3");
    check(file_wr_addr_r, 12'h550, "bank five");
    // reset in the middle of a multiply
    issue(16'h0dff, 21'h0);
    @(negedge clk);
    arst_n = 1'b0;
    #1;
    check_reset();
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    run_row(rows[21]);
    report_and_stop();
  end
endmodule
